/* shared/memory_map_pkg.sv */
// Constants, types and address map for the program and data memory map block
package memory_map_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PC_WIDTH        = 13;
    localparam int PROG_WORD_WIDTH = 14;
    localparam int DATA_WIDTH      = 8;
    localparam int FILE_ADDR_WIDTH = 7;
    localparam int DATA_ADDR_WIDTH = 8;
    localparam int LATCH_WIDTH     = 5;
    localparam int RAM_INDEX_WIDTH = 8;

    // ************************************************************
    // Program space
    // ************************************************************
    localparam logic [12:0] RESET_VECTOR    = 13'h0000;
    localparam logic [12:0] INT_VECTOR      = 13'h0004;
    localparam logic [12:0] SMALL_PROG_MASK = 13'h03ff;
    localparam logic [12:0] LARGE_PROG_MASK = 13'h07ff;

    // ************************************************************
    // Data space: bank selection and special function offsets
    // ************************************************************
    localparam int          BANK_SELECT_POS = 5;
    localparam int          BANK_SPAN       = 128;
    localparam logic [6:0]  OFS_INDIRECT    = 7'h00;
    localparam logic [7:0]  OFS_TIMER       = 8'h01;
    localparam logic [6:0]  OFS_PC_LOW      = 7'h02;
    localparam logic [6:0]  OFS_STATUS      = 7'h03;
    localparam logic [6:0]  OFS_POINTER     = 7'h04;
    localparam logic [7:0]  OFS_PORT        = 8'h05;
    localparam logic [6:0]  OFS_PC_LATCH    = 7'h0a;
    localparam logic [6:0]  OFS_IRQ_CTRL    = 7'h0b;
    localparam logic [7:0]  OFS_IRQ_FLAGS   = 8'h0c;
    localparam logic [7:0]  OFS_CONV_RESULT = 8'h1e;
    localparam logic [7:0]  OFS_CONV_CTRL_A = 8'h1f;
    localparam logic [7:0]  OFS_OPTION      = 8'h81;
    localparam logic [7:0]  OFS_DIRECTION   = 8'h85;
    localparam logic [7:0]  OFS_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0]  OFS_POWER       = 8'h8e;
    localparam logic [7:0]  OFS_OSC_CAL     = 8'h8f;
    localparam logic [7:0]  OFS_CONV_CTRL_B = 8'h9f;

    // ************************************************************
    // General purpose RAM windows
    // ************************************************************
    localparam logic [7:0] GPR0_FIRST   = 8'h20;
    localparam logic [7:0] GPR0_LAST    = 8'h7f;
    localparam logic [7:0] GPR1_FIRST   = 8'ha0;
    localparam logic [7:0] GPR1_LAST    = 8'hef;
    localparam logic [7:0] COMMON_FIRST = 8'hf0;
    localparam logic [7:0] COMMON_BASE  = 8'h70;
    localparam logic [7:0] GPR1_INDEX0  = 8'h60;
    localparam int         RAM_DEPTH    = 176;

    // ************************************************************
    // Core register reset values and masks
    // ************************************************************
    localparam logic [7:0] STATUS_RESET   = 8'h18;
    localparam logic [7:0] STATUS_WR_MASK = 8'h27;
    localparam logic [7:0] ALU_FLAG_MASK  = 8'h07;
    localparam logic [7:0] POINTER_RESET  = 8'h00;
    localparam logic [4:0] PC_LATCH_RESET = 5'h00;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

    typedef enum logic [3:0] {
        TGT_NONE, TGT_INDIRECT, TGT_PC_LOW, TGT_STATUS, TGT_POINTER,
        TGT_PC_LATCH, TGT_IRQ_CTRL, TGT_PERIPH, TGT_RAM
    } target_t;

    typedef struct packed {
        target_t     target;
        logic [7:0]  ram_index;
    } decode_t;

    typedef struct packed {
        logic        active;
        logic        write;
        logic [6:0]  file_addr;
        logic [7:0]  wdata;
    } data_req_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } periph_bus_t;

endpackage : memory_map_pkg

/* rtl/program_data_memory_map.sv */
// Program counter, data bank decode, core registers and general purpose RAM
`timescale 1ns/100ps

// Operation
// - Program counter is 13 bits, addressing 8K words of 14 bits.
// - Small variant implements program words 0000h to 03FFh only.
// - Large variant implements program words 0000h to 07FFh only.
// - Fetches above implemented size wrap using low address bits, no fault.
// - Any reset loads program counter with 0000h.
// - Taking an interrupt loads program counter with 0004h.
// - Status bit 5 selects bank 1 when set, bank 0 when clear.
// - Each bank holds 128 byte offsets, 00h to 7Fh.
// - Low offsets decode to special registers, higher ones to static RAM.
// - Frequently used core registers appear identically in both banks.
// - Bank 1 F0h to FFh share RAM with bank 0 70h to 7Fh.
// - Registers reachable directly or indirectly through the file select pointer.
// - Operand read in second quarter, destination written in fourth quarter.
module program_data_memory_map
    import memory_map_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        reset_in,
    // Program counter control from the core
    input  wire logic                        interrupt_take_in,
    input  wire logic                        jump_in,
    input  wire logic [PC_WIDTH-1:0]         jump_addr_in,
    // Program fetch address
    output      logic [PC_WIDTH-1:0]         prog_addr_out,
    output      logic [PC_WIDTH-1:0]         pc_out,
    output      phase_t                      phase_out,
    // Data operand access from the core
    input  wire data_req_t                   data_req_in,
    input  wire logic                        alu_flags_we_in,
    input  wire logic [2:0]                  alu_flags_in,
    output      logic [DATA_WIDTH-1:0]       rdata_out,
    // Core register state
    output      logic [DATA_WIDTH-1:0]       status_out,
    output      logic [DATA_WIDTH-1:0]       pointer_out,
    output      logic [LATCH_WIDTH-1:0]      pc_latch_out,
    output      logic [DATA_WIDTH-1:0]       irq_ctrl_out,
    // Peripheral register access
    output      periph_bus_t                 periph_out,
    input  wire logic [DATA_WIDTH-1:0]       periph_rdata_in
);

    // ************************************************************
    // Declarations
    // ************************************************************
    phase_t                      phase_q;
    phase_t                      phase_d;
    logic [PC_WIDTH-1:0]         pc_q;
    logic [PC_WIDTH-1:0]         pc_d;
    logic [DATA_WIDTH-1:0]       status_q;
    logic [DATA_WIDTH-1:0]       status_d;
    logic [DATA_WIDTH-1:0]       pointer_q;
    logic [LATCH_WIDTH-1:0]      pc_latch_q;
    logic [DATA_WIDTH-1:0]       irq_ctrl_q;
    logic [DATA_WIDTH-1:0]       rdata_q;
    logic [DATA_ADDR_WIDTH-1:0]  eff_addr_q;
    logic [DATA_ADDR_WIDTH-1:0]  eff_addr_d;
    logic                        active_q;
    logic                        write_q;
    logic [DATA_WIDTH-1:0]       wdata_q;
    logic [DATA_WIDTH-1:0]       ram_q [RAM_DEPTH];
    decode_t                     dec;
    logic                        bank_select_bit;
    logic                        do_read;
    logic                        do_write;
    logic [DATA_WIDTH-1:0]       read_value;

    // ************************************************************
    // Functions
    // ************************************************************

    // True for an address that belongs to a peripheral register
    // Mirrored core offsets are decoded before this test
    function automatic logic is_periph(input logic [7:0] addr);
        is_periph = (addr == OFS_TIMER) || (addr == OFS_PORT) ||
                    (addr == OFS_IRQ_FLAGS) || (addr == OFS_CONV_RESULT) ||
                    (addr == OFS_CONV_CTRL_A) || (addr == OFS_OPTION) ||
                    (addr == OFS_DIRECTION) || (addr == OFS_IRQ_ENABLES) ||
                    (addr == OFS_POWER) || (addr == OFS_OSC_CAL) ||
                    (addr == OFS_CONV_CTRL_B);
    endfunction : is_periph

    // Map an 8-bit data address onto a target and a RAM index
    function automatic decode_t decode_addr(input logic [7:0] addr);
        decode_t     d;
        logic [6:0]  ofs;
        d         = '{target: TGT_NONE, ram_index: 8'h00};
        ofs       = addr[6:0];
        // Special registers sit below 20h in each bank
        // Core registers mirrored in both banks, bank bit ignored
        if (ofs == OFS_INDIRECT) begin
            d.target = TGT_INDIRECT;
        end else if (ofs == OFS_PC_LOW) begin
            d.target = TGT_PC_LOW;
        end else if (ofs == OFS_STATUS) begin
            d.target = TGT_STATUS;
        end else if (ofs == OFS_POINTER) begin
            d.target = TGT_POINTER;
        end else if (ofs == OFS_PC_LATCH) begin
            d.target = TGT_PC_LATCH;
        end else if (ofs == OFS_IRQ_CTRL) begin
            d.target = TGT_IRQ_CTRL;
        end else if (is_periph(addr)) begin
            d.target = TGT_PERIPH;
        end else if (addr >= GPR0_FIRST && addr <= GPR0_LAST) begin
            d.target    = TGT_RAM;
            d.ram_index = addr - GPR0_FIRST;
        end else if (addr >= GPR1_FIRST && addr <= GPR1_LAST) begin
            d.target    = TGT_RAM;
            d.ram_index = addr - GPR1_FIRST + GPR1_INDEX0;
        end else if (addr >= COMMON_FIRST) begin
            d.target    = TGT_RAM;
            d.ram_index = addr - COMMON_FIRST + COMMON_BASE - GPR0_FIRST;
        end
        decode_addr = d;
    endfunction : decode_addr

    // ************************************************************
    // Quarter cycle sequencer
    // ************************************************************

    // Four quarters per instruction cycle, one per clock
    always_comb begin
        unique case (phase_q)
            PH_Q1: phase_d = PH_Q2;
            PH_Q2: phase_d = PH_Q3;
            PH_Q3: phase_d = PH_Q4;
            PH_Q4: phase_d = PH_Q1;
        endcase
    end

    // Quarter register, restarts at Q1
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_q <= PH_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Current quarter to the core
    assign phase_out = phase_q;

    // ************************************************************
    // Program counter
    // ************************************************************

    // Increment in Q1, redirect in Q4; interrupt beats jump beats low-byte write
    // A low-byte write takes its high bits from the latch
    always_comb begin
        pc_d = pc_q;
        if (phase_q == PH_Q1) begin
            pc_d = pc_q + 13'h0001;
        end else if (phase_q == PH_Q4) begin
            if (interrupt_take_in) begin
                pc_d = INT_VECTOR;
            end else if (jump_in) begin
                pc_d = jump_addr_in;
            end else if (do_write && dec.target == TGT_PC_LOW) begin
                pc_d = {pc_latch_q, wdata_q};
            end
        end
    end

    // Counter register, any reset restarts at the reset vector
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pc_q <= RESET_VECTOR;
        end else begin
            pc_q <= pc_d;
        end
    end

    // Only the low bits reach the array, so high addresses wrap
    // The unmasked counter stays visible on its own port
    assign prog_addr_out = LARGE_VARIANT ? (pc_q & LARGE_PROG_MASK)
                                         : (pc_q & SMALL_PROG_MASK);
    assign pc_out        = pc_q;

    // ************************************************************
    // Operand address capture
    // ************************************************************

    // Direct uses bank bit and file offset, indirect uses the pointer
    assign bank_select_bit = status_q[BANK_SELECT_POS];
    always_comb begin
        if (data_req_in.file_addr == OFS_INDIRECT) begin
            eff_addr_d = pointer_q;
        end else begin
            eff_addr_d = {bank_select_bit, data_req_in.file_addr};
        end
    end

    // Request latched in Q1, held for the rest of the cycle
    // A status or pointer write moves only the next address
    // The result is ready in Q3, so write data is taken again
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            eff_addr_q <= 8'h00;
            active_q   <= 1'b0;
            write_q    <= 1'b0;
            wdata_q    <= 8'h00;
        end else if (phase_q == PH_Q1) begin
            eff_addr_q <= eff_addr_d;
            active_q   <= data_req_in.active;
            write_q    <= data_req_in.write;
            wdata_q    <= data_req_in.wdata;
        end else if (phase_q == PH_Q3) begin
            wdata_q    <= data_req_in.wdata;
        end
    end

    // Decode of the held address and the quarter strobes
    assign dec      = decode_addr(eff_addr_q);
    assign do_read  = active_q && (phase_q == PH_Q2);
    assign do_write = active_q && write_q && (phase_q == PH_Q4);

    // ************************************************************
    // Operand read
    // ************************************************************

    // Read multiplexer; holes and the pointer-to-itself case give zero
    // The pointer aimed at its own port would loop, so it reads zero
    always_comb begin
        read_value = 8'h00;
        unique case (dec.target)
            TGT_PC_LOW:   read_value = pc_q[7:0];
            TGT_STATUS:   read_value = status_q;
            TGT_POINTER:  read_value = pointer_q;
            TGT_PC_LATCH: read_value = {3'h0, pc_latch_q};
            TGT_IRQ_CTRL: read_value = irq_ctrl_q;
            TGT_PERIPH:   read_value = periph_rdata_in;
            TGT_RAM:      read_value = ram_q[dec.ram_index];
            TGT_INDIRECT: read_value = 8'h00;
            TGT_NONE:     read_value = 8'h00;
            default:      read_value = 8'h00;
        endcase
    end

    // Operand captured at the end of Q2
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_q <= 8'h00;
        end else if (do_read) begin
            rdata_q <= read_value;
        end
    end

    // Operand register to the core
    assign rdata_out = rdata_q;

    // ************************************************************
    // Destination write: core registers
    // ************************************************************

    // ALU flags first, an explicit write of status overrides writable bits
    // Bits 7 and 6 are outside the mask and always read zero
    always_comb begin
        status_d = status_q;
        if (phase_q == PH_Q4 && alu_flags_we_in) begin
            status_d = (status_q & ~ALU_FLAG_MASK) | {5'h00, alu_flags_in};
        end
        if (do_write && dec.target == TGT_STATUS) begin
            status_d = (status_d & ~STATUS_WR_MASK) | (wdata_q & STATUS_WR_MASK);
        end
    end

    // Status register; bits 4 and 3 change only on reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // File select pointer
    // Eight bits wide, so it reaches both banks without the bank bit
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pointer_q <= POINTER_RESET;
        end else if (do_write && dec.target == TGT_POINTER) begin
            pointer_q <= wdata_q;
        end
    end

    // Program counter high latch, only five bits kept
    // The top three bits read back as zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pc_latch_q <= PC_LATCH_RESET;
        end else if (do_write && dec.target == TGT_PC_LATCH) begin
            pc_latch_q <= wdata_q[LATCH_WIDTH-1:0];
        end
    end

    // Interrupt control
    // Plain storage; the logic that acts on it sits in the core
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_ctrl_q <= IRQ_CTRL_RESET;
        end else if (do_write && dec.target == TGT_IRQ_CTRL) begin
            irq_ctrl_q <= wdata_q;
        end
    end

    // Core register state to the core
    assign status_out   = status_q;
    assign pointer_out  = pointer_q;
    assign pc_latch_out = pc_latch_q;
    assign irq_ctrl_out = irq_ctrl_q;

    // ************************************************************
    // Destination write: general purpose RAM
    // ************************************************************

    // Common window shares storage through the decoded index
    // No reset: the RAM keeps whatever was last written
    always_ff @(posedge clk_in) begin
        if (do_write && dec.target == TGT_RAM) begin
            ram_q[dec.ram_index] <= wdata_q;
        end
    end

    // ************************************************************
    // Peripheral register strobes
    // ************************************************************

    // Read strobe in Q2, write strobe in Q4; holes raise neither
    // Mirrored core offsets never reach the peripherals
    assign periph_out.rd    = do_read && (dec.target == TGT_PERIPH);
    assign periph_out.wr    = do_write && (dec.target == TGT_PERIPH);
    assign periph_out.addr  = eff_addr_q;
    assign periph_out.wdata = wdata_q;

endmodule : program_data_memory_map

/* bench/program_data_memory_map_assertions.sv */
// Concurrent checks on the memory map block's ports
`timescale 1ns/100ps
module program_data_memory_map_assertions
    import memory_map_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        reset_in,
    // Program counter
    input wire logic        interrupt_take_in,
    input wire logic        jump_in,
    input wire logic [12:0] jump_addr_in,
    input wire logic [12:0] prog_addr_out,
    input wire logic [12:0] pc_out,
    input wire phase_t      phase_out,
    // Data side
    input wire logic [7:0]  rdata_out,
    input wire periph_bus_t periph_out,
    input wire logic [7:0]  periph_rdata_in
);
    localparam logic [12:0] MASK = LARGE_VARIANT ? 13'h07ff : 13'h03ff;
    // Reset seen at the last edge keeps the release edge out of checks
    logic reset_seen_q;
    always_ff @(posedge clk_in) begin
        reset_seen_q <= reset_in;
    end
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in || reset_seen_q);
    AST_FETCH_MASK: assert property (
        prog_addr_out == (pc_out & MASK)) else $error("fetch address not masked");
    AST_RESET_VECTOR: assert property (disable iff (1'b0)
        reset_in |=> pc_out == 13'h0000 && phase_out == PH_Q1) else $error("reset state");
    AST_IRQ_VECTOR: assert property (
        phase_out == PH_Q4 && interrupt_take_in |=> pc_out == 13'h0004)
        else $error("interrupt vector");
    AST_JUMP_LOAD: assert property (
        phase_out == PH_Q4 && jump_in && !interrupt_take_in |=> pc_out == $past(jump_addr_in))
        else $error("jump target");
    AST_PC_STEP: assert property (
        phase_out == PH_Q1 |=> pc_out == $past(pc_out) + 13'h1) else $error("pc step");
    AST_PC_HOLD: assert property (
        phase_out inside {PH_Q2, PH_Q3} |=> $stable(pc_out)) else $error("pc moved");
    AST_QUARTERS: assert property (
        phase_out == PH_Q1 |=> phase_out == PH_Q2 ##1 phase_out == PH_Q3
        ##1 phase_out == PH_Q4 ##1 phase_out == PH_Q1) else $error("quarter order");
    AST_PERIPH_RD_Q2: assert property (
        periph_out.rd |-> phase_out == PH_Q2) else $error("read outside Q2");
    AST_PERIPH_WR_Q4: assert property (
        periph_out.wr |-> phase_out == PH_Q4) else $error("write outside Q4");
    AST_OPERAND_HOLD: assert property (
        phase_out != PH_Q2 |=> $stable(rdata_out)) else $error("operand moved");
    AST_PERIPH_DATA: assert property (
        periph_out.rd |=> rdata_out == $past(periph_rdata_in)) else $error("periph data");
endmodule : program_data_memory_map_assertions

bind program_data_memory_map program_data_memory_map_assertions #(
    .LARGE_VARIANT(LARGE_VARIANT)
) u_program_data_memory_map_assertions (
    .clk_in, .reset_in, .interrupt_take_in, .jump_in, .jump_addr_in, .prog_addr_out,
    .pc_out, .phase_out, .rdata_out, .periph_out, .periph_rdata_in
);

/* bench/core_access_model.sv */
// Core-side model: redirects, operand accesses and a peripheral responder
`timescale 1ns/100ps
module core_access_model
    import memory_map_pkg::*;
(
    // Clock and design state
    input  wire logic        clk_in,
    input  wire phase_t      phase_in,
    input  wire logic [7:0]  rdata_in,
    input  wire periph_bus_t periph_in,
    // Drives towards the design
    output      logic        interrupt_take_out,
    output      logic        jump_out,
    output      logic [12:0] jump_addr_out,
    output      data_req_t   data_req_out,
    output      logic        alu_flags_we_out,
    output      logic [2:0]  alu_flags_out,
    output      logic [7:0]  periph_rdata_out,
    // Last peripheral write seen
    output      logic [15:0] periph_wr_seen_out
);
    logic [7:0] last_q;
    // ****************
    // Peripheral side
    // ****************
    // Data only in Q2 while read is up, inverse of last value otherwise
    assign periph_rdata_out = periph_in.rd ? (periph_in.addr ^ 8'h3c) : ~last_q;
    initial begin
        {interrupt_take_out, jump_out, jump_addr_out} = '0;
        {data_req_out, alu_flags_we_out, alu_flags_out} = '0;
        {last_q, periph_wr_seen_out} = '0;
    end
    // Remember read data and writes
    always @(posedge clk_in) begin
        if (periph_in.rd) last_q <= periph_in.addr ^ 8'h3c;
        if (periph_in.wr) periph_wr_seen_out <= {periph_in.addr, periph_in.wdata};
    end
    // ****************
    // Core requests
    // ****************
    // Returns at the edge that ends the given quarter
    task automatic wait_end_of(input phase_t ph);
        do @(posedge clk_in); while (phase_in !== ph);
    endtask : wait_end_of
    // Operand read in Q2, destination written in Q4
    task automatic access(input logic wr, input logic [6:0] fa, input logic [7:0] wd,
                          output logic [7:0] rd);
        wait_end_of(PH_Q4);
        data_req_out <= '{1'b1, wr, fa, wd};
        wait_end_of(PH_Q3);
        rd = rdata_in;
        wait_end_of(PH_Q4);
        data_req_out.active <= 1'b0;
    endtask : access
    // Redirect presented for one Q4 only
    task automatic redirect(input logic irq, input logic jmp, input logic [12:0] a);
        wait_end_of(PH_Q3);
        interrupt_take_out <= irq;
        jump_out <= jmp;
        jump_addr_out <= a;
        wait_end_of(PH_Q4);
        interrupt_take_out <= 1'b0;
        jump_out <= 1'b0;
    endtask : redirect
    // ALU flag update presented for one Q4 only
    task automatic set_flags(input logic [2:0] f);
        wait_end_of(PH_Q3);
        alu_flags_we_out <= 1'b1;
        alu_flags_out <= f;
        wait_end_of(PH_Q4);
        alu_flags_we_out <= 1'b0;
    endtask : set_flags
endmodule : core_access_model

/* bench/tb_program_data_memory_map.sv */
// Self-checking bench for the program and data memory map
`timescale 1ns/100ps
module tb_program_data_memory_map;
    import memory_map_pkg::*;
    logic        clk_in   = 1'b0;
    logic        reset_in = 1'b1;
    logic        irq, jmp, flags_we;
    logic [2:0]  flags;
    logic [12:0] jaddr, prog_addr, prog_addr_small, pc;
    phase_t      phase;
    data_req_t   req;
    logic [7:0]  rdata, prdata, rd;
    periph_bus_t pbus;
    logic [15:0] wr_seen;
    logic [7:0]  status, ptr, ictl;
    logic [4:0]  latch;
    int          fails = 0;
    int          samples_checked = 0;
    // ****************
    // Instances
    // ****************
    always #25 clk_in = ~clk_in;
    program_data_memory_map #(.LARGE_VARIANT(1'b1)) u_program_data_memory_map (
        .clk_in, .reset_in, .interrupt_take_in(irq), .jump_in(jmp), .jump_addr_in(jaddr),
        .prog_addr_out(prog_addr), .pc_out(pc), .phase_out(phase), .data_req_in(req),
        .alu_flags_we_in(flags_we), .alu_flags_in(flags), .rdata_out(rdata),
        .status_out(status), .pointer_out(ptr), .pc_latch_out(latch), .irq_ctrl_out(ictl),
        .periph_out(pbus), .periph_rdata_in(prdata));
    program_data_memory_map #(.LARGE_VARIANT(1'b0)) u_program_data_memory_map_small (
        .clk_in, .reset_in, .interrupt_take_in(irq), .jump_in(jmp), .jump_addr_in(jaddr),
        .prog_addr_out(prog_addr_small), .pc_out(), .phase_out(), .data_req_in(req),
        .alu_flags_we_in(flags_we), .alu_flags_in(flags), .rdata_out(),
        .status_out(), .pointer_out(), .pc_latch_out(), .irq_ctrl_out(),
        .periph_out(), .periph_rdata_in(prdata));
    core_access_model u_core_access_model (
        .clk_in, .phase_in(phase), .rdata_in(rdata), .periph_in(pbus),
        .interrupt_take_out(irq), .jump_out(jmp), .jump_addr_out(jaddr),
        .data_req_out(req), .alu_flags_we_out(flags_we), .alu_flags_out(flags),
        .periph_rdata_out(prdata), .periph_wr_seen_out(wr_seen));
    // ****************
    // Tasks
    // ****************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [6:0] fa, input logic [7:0] wd);
        u_core_access_model.access(1'b1, fa, wd, rd);
    endtask : wr
    task automatic rdc(input string name, input logic [6:0] fa, input logic [7:0] exp);
        u_core_access_model.access(1'b0, fa, 8'h00, rd);
        check(name, {8'h00, rd}, {8'h00, exp});
    endtask : rdc
    task automatic end_of_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        check("pc_reset", {3'b000, pc}, 16'h0000);
        wr(7'h20, 8'ha5);
        wr(7'h7f, 8'h3c);
        rdc("ram_20", 7'h20, 8'ha5);
        wr(7'h03, 8'h20);
        rdc("common_ff", 7'h7f, 8'h3c);
        check("status_bank1", {8'h00, status}, 16'h0038);
        wr(7'h20, 8'h5a);
        wr(7'h04, 8'ha0);
        wr(7'h0b, 8'hc3);
        rdc("indirect_a0", 7'h00, 8'h5a);
        check("pointer", {8'h00, ptr}, 16'h00a0);
        check("irq_ctrl", {8'h00, ictl}, 16'h00c3);
        rdc("periph_81", 7'h01, 8'hbd);
        wr(7'h05, 8'h77);
        @(posedge clk_in);
        check("periph_wr", wr_seen, 16'h8577);
        wr(7'h06, 8'hff);
        rdc("hole_86", 7'h06, 8'h00);
        wr(7'h03, 8'h00);
        u_core_access_model.set_flags(3'h5);
        @(posedge clk_in);
        check("alu_flags", {8'h00, status}, 16'h001d);
        rdc("bank0_20", 7'h20, 8'ha5);
        rdc("ptr_mirror", 7'h04, 8'ha0);
        rdc("irq_ctrl_mirror", 7'h0b, 8'hc3);
        wr(7'h0a, 8'h05);
        wr(7'h02, 8'h10);
        @(posedge clk_in);
        check("pc_low_wr", {3'b000, pc}, 16'h0510);
        check("pc_latch", {11'h000, latch}, 16'h0005);
        u_core_access_model.redirect(1'b0, 1'b1, 13'h1634);
        @(posedge clk_in);
        check("pc_jump", {3'b000, pc}, 16'h1634);
        check("fetch_large", {3'b000, prog_addr}, 16'h0634);
        check("fetch_small", {3'b000, prog_addr_small}, 16'h0234);
        @(posedge clk_in);
        check("pc_step", {3'b000, pc}, 16'h1635);
        u_core_access_model.redirect(1'b1, 1'b1, 13'h1fff);
        @(posedge clk_in);
        check("pc_irq", {3'b000, pc}, 16'h0004);
        reset_in <= 1'b1;
        @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        check("pc_rereset", {3'b000, pc}, 16'h0000);
        end_of_test();
    end
    // Watchdog well beyond the expected fewer than two hundred cycles
    initial begin
        repeat (3000) @(posedge clk_in);
        fails++;
        end_of_test();
    end
endmodule : tb_program_data_memory_map
